// ==== sbs_ctrl_model.sv ====
`timescale 1ns/1ps
`include "sbs_params.svh"

module sbs_ctrl_model
(
    // clock
    input  wire logic                  sys_clk_i,
    // pins toward the memory
    output sbs_pkg::sbs_ctrl_type      ctrl_o,
    output logic [`SBS_ADDR_W-1:0]     addr_o,
    output logic [`SBS_DATA_W-1:0]     wdata_o,
    output logic                       oe_n_o,
    output logic                       sleep_o
);
    initial
    begin
        ctrl_o  = 12'hd7f;
        addr_o  = `SBS_RST_ADDR;
        wdata_o = `SBS_RST_DATA;
        oe_n_o  = 1'b0;
        sleep_o = 1'b0;
    end

    // ------------------------------------------------------------
    // one bus cycle, held until the next rising edge
    // ------------------------------------------------------------
    task automatic pins(input sbs_pkg::sbs_ctrl_type c, input logic [`SBS_ADDR_W-1:0] a,
                        input logic [`SBS_DATA_W-1:0] d);
        @(posedge sys_clk_i);
        ctrl_o  <= c;
        addr_o  <= a;
        // released data shows the inverse of the last value
        wdata_o <= (!c.full_word_write_n || !c.byte_write_gate_n) ? d : ~wdata_o;
    endtask : pins

    task automatic levels(input logic oe_n, input logic sleep);
        @(posedge sys_clk_i);
        oe_n_o  <= oe_n;
        sleep_o <= sleep;
    endtask : levels
endmodule : sbs_ctrl_model

// ==== sbs_params.svh ====
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH

// ------------------------------------------------------------
// geometry
// ------------------------------------------------------------
`define SBS_ADDR_W      18
`define SBS_DATA_W      36
`define SBS_LANES       4
`define SBS_LANE_W      9
`define SBS_MEM_DEPTH   262144

// ------------------------------------------------------------
// burst order encodings
// ------------------------------------------------------------
`define SBS_ORDER_LINEAR      1'b0
`define SBS_ORDER_INTERLEAVED 1'b1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SBS_RST_ADDR   18'h00000
`define SBS_RST_BURST  2'h0
`define SBS_RST_DATA   36'h000000000

`endif

// ==== sbs_pkg.sv ====
`include "sbs_params.svh"

package sbs_pkg;

    // ------------------------------------------------------------
    // cycle kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SBS_IDLE  = 2'b00,
        SBS_READ  = 2'b01,
        SBS_WRITE = 2'b10
    } sbs_cycle_type;

    // ------------------------------------------------------------
    // sampled synchronous control pins
    // ------------------------------------------------------------
    typedef struct packed {
        logic       chip_sel_n;
        logic       secondary_select_hi;
        logic       third_sel_n;
        logic       proc_addr_strobe_n;
        logic       ctrl_addr_strobe_n;
        logic       burst_advance_n;
        logic       byte_write_gate_n;
        logic       full_word_write_n;
        logic [3:0] byte_lane_wr_n;
    } sbs_ctrl_type;

endpackage : sbs_pkg

// ==== sbs_sram.sv ====
`timescale 1ns/1ps
`include "sbs_params.svh"

// Functional notes
// - address, data, enables, write and burst controls captured on rising clock
// - external address registered at the edge when a new address loads
// - low two address bits come from burst counter during burst and wait
// - lane write enable low writes its lane, all high reads; lanes map one to one
// - lane write enables act only while byte write gate is low
// - full word write low writes all 36 bits regardless of lane enables
// - data pins released when a lane enable is low with byte write gate low
// - primary enable selects device and gates processor address strobe
// - active-high secondary select must also be asserted for selection
// - optional third active-low select also required where present
// - output enable gates data drivers; high means no drive
// - advance low steps burst counter; high is a wait cycle
// - processor strobe with primary enable loads address and starts read when selected
// - controller strobe selects by enables, loads address, reads or writes
// - order select low gives linear burst, high interleaved
// - sleep high puts device in standby
// - lane 0 is first byte, lane 3 the fourth
module sbs_sram
(
    // clock and reset
    input  wire logic                      sys_clk_i,
    input  wire logic                      arst_n_i,
    input  wire logic                      clk_en_i,
    // address and control pins
    input  wire logic [`SBS_ADDR_W-1:0]    addr_i,
    input  wire logic                      chip_sel_n_i,
    input  wire logic                      secondary_select_hi_i,
    input  wire logic                      third_sel_present_i,
    input  wire logic                      third_sel_n_i,
    input  wire logic                      proc_addr_strobe_n_i,
    input  wire logic                      ctrl_addr_strobe_n_i,
    input  wire logic                      burst_advance_n_i,
    input  wire logic                      byte_write_gate_n_i,
    input  wire logic                      full_word_write_n_i,
    input  wire logic [3:0]                byte_lane_wr_n_i,
    input  wire logic                      output_enable_n_i,
    input  wire logic                      burst_order_i,
    input  wire logic                      sleep_request_i,
    // data pins
    input  wire logic [`SBS_DATA_W-1:0]    data_i,
    output logic      [`SBS_DATA_W-1:0]    data_o,
    output logic      [`SBS_LANES-1:0]     data_oe_o,
    // status
    output logic                           standby_o
);

    // ------------------------------------------------------------
    // two-stage input synchronisers
    // ------------------------------------------------------------
    sbs_pkg::sbs_ctrl_type            ctrl_meta_reg;
    sbs_pkg::sbs_ctrl_type            ctrl_reg;
    sbs_pkg::sbs_ctrl_type            ctrl_pin;
    logic [`SBS_ADDR_W-1:0]           addr_meta_reg;
    logic [`SBS_ADDR_W-1:0]           addr_s_reg;
    logic [`SBS_DATA_W-1:0]           din_meta_reg;
    logic [`SBS_DATA_W-1:0]           din_reg;
    logic [2:0]                       async_meta_reg;
    logic [2:0]                       async_reg;
    logic                             present_meta_reg;
    logic                             present_reg;

    assign ctrl_pin = '{chip_sel_n:          chip_sel_n_i,
                        secondary_select_hi: secondary_select_hi_i,
                        third_sel_n:         third_sel_n_i,
                        proc_addr_strobe_n:  proc_addr_strobe_n_i,
                        ctrl_addr_strobe_n:  ctrl_addr_strobe_n_i,
                        burst_advance_n:     burst_advance_n_i,
                        byte_write_gate_n:   byte_write_gate_n_i,
                        full_word_write_n:   full_word_write_n_i,
                        byte_lane_wr_n:      byte_lane_wr_n_i};

    // control pins
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl_meta_reg    <= '1;
            ctrl_reg         <= '1;
        end
        else if (clk_en_i)
        begin
            ctrl_meta_reg    <= ctrl_pin;
            ctrl_reg         <= ctrl_meta_reg;
        end
    end

    // address pins
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            addr_meta_reg    <= `SBS_RST_ADDR;
            addr_s_reg       <= `SBS_RST_ADDR;
        end
        else if (clk_en_i)
        begin
            addr_meta_reg    <= addr_i;
            addr_s_reg       <= addr_meta_reg;
        end
    end

    // write data pins
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            din_meta_reg     <= `SBS_RST_DATA;
            din_reg          <= `SBS_RST_DATA;
        end
        else if (clk_en_i)
        begin
            din_meta_reg     <= data_i;
            din_reg          <= din_meta_reg;
        end
    end

    // level pins: output enable, burst order, sleep
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            async_meta_reg   <= 3'h1;
            async_reg        <= 3'h1;
        end
        else if (clk_en_i)
        begin
            async_meta_reg   <= {sleep_request_i, burst_order_i, output_enable_n_i};
            async_reg        <= async_meta_reg;
        end
    end

    // package variant strap
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            present_meta_reg <= 1'b0;
            present_reg      <= 1'b0;
        end
        else if (clk_en_i)
        begin
            present_meta_reg <= third_sel_present_i;
            present_reg      <= present_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // decode of the sampled controls
    // ------------------------------------------------------------
    logic       oe_n;
    logic       order;
    logic       sleep;
    logic       selected;
    logic       proc_load;
    logic       ctrl_load;
    logic [3:0] lane_we;
    logic       any_write;

    assign oe_n  = async_reg[0];
    assign order = async_reg[1];
    assign sleep = async_reg[2];

    assign selected = !ctrl_reg.chip_sel_n
                    && ctrl_reg.secondary_select_hi
                    && (!present_reg || !ctrl_reg.third_sel_n);

    // processor strobe is ignored unless the primary enable is low
    assign proc_load = !ctrl_reg.proc_addr_strobe_n && !ctrl_reg.chip_sel_n;
    assign ctrl_load = !ctrl_reg.ctrl_addr_strobe_n && !proc_load;

    function automatic logic [3:0] lane_write
    (
        input sbs_pkg::sbs_ctrl_type c
    );
        if (!c.full_word_write_n)
            lane_write = 4'hf;
        else if (!c.byte_write_gate_n)
            lane_write = ~c.byte_lane_wr_n;
        else
            lane_write = 4'h0;
    endfunction : lane_write

    function automatic logic [1:0] burst_addr
    (
        input logic [1:0] start,
        input logic [1:0] count,
        input logic       ord
    );
        if (ord == `SBS_ORDER_LINEAR)
            burst_addr = start + count;
        else
            burst_addr = start ^ count;
    endfunction : burst_addr

    assign lane_we   = lane_write(ctrl_reg);
    assign any_write = |lane_we;

    // ------------------------------------------------------------
    // address and burst counter
    // ------------------------------------------------------------
    sbs_pkg::sbs_cycle_type           cycle_reg;
    logic [`SBS_ADDR_W-1:0]           base_reg;
    logic [1:0]                       count_reg;
    logic [`SBS_ADDR_W-1:0]           cur_addr;

    assign cur_addr = {base_reg[`SBS_ADDR_W-1:2],
                       burst_addr(base_reg[1:0], count_reg, order)};

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cycle_reg <= sbs_pkg::SBS_IDLE;
            base_reg  <= `SBS_RST_ADDR;
            count_reg <= `SBS_RST_BURST;
        end
        else if (clk_en_i)
        begin
            if (sleep)
                cycle_reg <= sbs_pkg::SBS_IDLE;
            else if (proc_load)
            begin
                base_reg  <= addr_s_reg;
                count_reg <= `SBS_RST_BURST;
                cycle_reg <= selected ? sbs_pkg::SBS_READ : sbs_pkg::SBS_IDLE;
            end
            else if (ctrl_load)
            begin
                base_reg  <= addr_s_reg;
                count_reg <= `SBS_RST_BURST;
                if (!selected)
                    cycle_reg <= sbs_pkg::SBS_IDLE;
                else if (any_write)
                    cycle_reg <= sbs_pkg::SBS_WRITE;
                else
                    cycle_reg <= sbs_pkg::SBS_READ;
            end
            else if (cycle_reg != sbs_pkg::SBS_IDLE)
            begin
                if (!ctrl_reg.burst_advance_n)
                    count_reg <= count_reg + 2'h1;
                if (any_write)
                    cycle_reg <= sbs_pkg::SBS_WRITE;
                else
                    cycle_reg <= sbs_pkg::SBS_READ;
            end
        end
    end

    // ------------------------------------------------------------
    // storage array and self-timed write
    // ------------------------------------------------------------
    logic [`SBS_DATA_W-1:0] mem_array [0:`SBS_MEM_DEPTH-1];
    logic [`SBS_DATA_W-1:0] wr_data_reg;
    logic [3:0]             wr_lane_reg;
    logic [`SBS_ADDR_W-1:0] wr_addr_reg;
    logic                   wr_pend_reg;
    logic                   wr_now;

    // data and lane enables seen in the same edge as a write cycle
    assign wr_now = !sleep && selected && any_write
                  && (ctrl_load || (!proc_load && cycle_reg != sbs_pkg::SBS_IDLE));

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_pend_reg <= 1'b0;
            wr_lane_reg <= 4'h0;
            wr_addr_reg <= `SBS_RST_ADDR;
            wr_data_reg <= `SBS_RST_DATA;
        end
        else if (clk_en_i)
        begin
            wr_pend_reg <= wr_now;
            wr_lane_reg <= lane_we;
            wr_addr_reg <= ctrl_load ? addr_s_reg : cur_addr;
            wr_data_reg <= din_reg;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (clk_en_i && wr_pend_reg)
        begin
            for (int i = 0; i < `SBS_LANES; i++)
            begin
                if (wr_lane_reg[i])
                    mem_array[wr_addr_reg][i*`SBS_LANE_W +: `SBS_LANE_W] <=
                        wr_data_reg[i*`SBS_LANE_W +: `SBS_LANE_W];
            end
        end
    end

    // ------------------------------------------------------------
    // read data and output drivers
    // ------------------------------------------------------------
    logic drive;

    // release during write cycles so the controller can drive the bus
    assign drive = !oe_n && !sleep
                && (cycle_reg == sbs_pkg::SBS_READ) && !any_write;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            data_o    <= `SBS_RST_DATA;
        end
        else if (clk_en_i)
        begin
            data_o    <= mem_array[cur_addr];
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            data_oe_o <= 4'h0;
        end
        else if (clk_en_i)
        begin
            data_oe_o <= {`SBS_LANES{drive}};
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            standby_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            standby_o <= sleep;
        end
    end

endmodule : sbs_sram

// ==== sbs_sram_chk.sv ====
`timescale 1ns/1ps

module sbs_sram_chk
(
    // clock and reset
    input wire logic       sys_clk_i,
    input wire logic       arst_n_i,
    // pins
    input wire logic       chip_sel_n_i,
    input wire logic       secondary_select_hi_i,
    input wire logic       third_sel_present_i,
    input wire logic       third_sel_n_i,
    input wire logic       proc_addr_strobe_n_i,
    input wire logic       ctrl_addr_strobe_n_i,
    input wire logic       byte_write_gate_n_i,
    input wire logic       full_word_write_n_i,
    input wire logic [3:0] byte_lane_wr_n_i,
    input wire logic       output_enable_n_i,
    input wire logic       sleep_request_i,
    input wire logic [3:0] data_oe_o,
    input wire logic       standby_o
);
    logic sel;
    logic wr;
    logic go;

    assign sel = !chip_sel_n_i && secondary_select_hi_i && !(third_sel_present_i && third_sel_n_i);
    assign wr  = !full_word_write_n_i || (!byte_write_gate_n_i && byte_lane_wr_n_i != 4'hf);
    assign go  = !output_enable_n_i && !sleep_request_i;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_oe_off; output_enable_n_i [*3] |=> data_oe_o == 4'h0; endproperty
    a_oe_off: assert property (p_oe_off) else $error("drive with oe high");
    property p_sleep_on; sleep_request_i [*3] |=> standby_o; endproperty
    a_sleep_on: assert property (p_sleep_on) else $error("no standby");
    property p_sleep_off; !sleep_request_i [*3] |=> !standby_o; endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("stuck standby");
    property p_sleep_quiet; standby_o && $past(standby_o) |-> data_oe_o == 4'h0; endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("drive in standby");
    property p_desel;
        !ctrl_addr_strobe_n_i && !sel && (proc_addr_strobe_n_i || chip_sel_n_i)
            |-> ##[3:4] data_oe_o == 4'h0;
    endproperty
    a_desel: assert property (p_desel) else $error("drive when deselected");
    property p_proc_read; !proc_addr_strobe_n_i && sel && go |-> ##[3:4] data_oe_o == 4'hf; endproperty
    a_proc_read: assert property (p_proc_read) else $error("no read drive");
    property p_ctrl_read;
        !ctrl_addr_strobe_n_i && proc_addr_strobe_n_i && sel && !wr && go
            |-> ##[3:4] data_oe_o == 4'hf;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("no read drive");
    property p_wr_quiet;
        !ctrl_addr_strobe_n_i && proc_addr_strobe_n_i && sel && wr |-> ##[3:4] data_oe_o == 4'h0;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("drive on write");
endmodule : sbs_sram_chk

bind sbs_sram sbs_sram_chk i_sbs_sram_chk
(
    .sys_clk_i, .arst_n_i, .chip_sel_n_i, .secondary_select_hi_i, .third_sel_present_i,
    .third_sel_n_i, .proc_addr_strobe_n_i, .ctrl_addr_strobe_n_i, .byte_write_gate_n_i,
    .full_word_write_n_i, .byte_lane_wr_n_i, .output_enable_n_i, .sleep_request_i,
    .data_oe_o, .standby_o
);

// ==== sbs_sram_tb.sv ====
`timescale 1ns/1ps
`include "sbs_params.svh"

module sbs_sram_tb;
    logic                   sys_clk_i;
    logic                   arst_n_i;
    logic                   order_reg;
    logic                   third_reg;
    sbs_pkg::sbs_ctrl_type  pc;
    logic [`SBS_ADDR_W-1:0] addr;
    logic [`SBS_DATA_W-1:0] wdata;
    logic [`SBS_DATA_W-1:0] rdata;
    logic [3:0]             oe_lanes;
    logic                   oe_n;
    logic                   sleep;
    logic                   standby;
    logic [`SBS_DATA_W-1:0] mem [16];
    int                     errors;
    int                     comparisons;

    sbs_ctrl_model i_sbs_ctrl_model (.sys_clk_i, .ctrl_o(pc), .addr_o(addr), .wdata_o(wdata),
                                     .oe_n_o(oe_n), .sleep_o(sleep));
    sbs_sram i_sbs_sram (.sys_clk_i, .arst_n_i, .clk_en_i(1'b1), .addr_i(addr),
        .chip_sel_n_i(pc.chip_sel_n), .secondary_select_hi_i(pc.secondary_select_hi),
        .third_sel_present_i(third_reg), .third_sel_n_i(pc.third_sel_n),
        .proc_addr_strobe_n_i(pc.proc_addr_strobe_n), .ctrl_addr_strobe_n_i(pc.ctrl_addr_strobe_n),
        .burst_advance_n_i(pc.burst_advance_n), .byte_write_gate_n_i(pc.byte_write_gate_n),
        .full_word_write_n_i(pc.full_word_write_n), .byte_lane_wr_n_i(pc.byte_lane_wr_n),
        .output_enable_n_i(oe_n), .burst_order_i(order_reg), .sleep_request_i(sleep),
        .data_i(wdata), .data_o(rdata), .data_oe_o(oe_lanes), .standby_o(standby));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // ------------------------------------------------------------
    // compares and closing
    // ------------------------------------------------------------
    task automatic chk_data(input string w, input logic [35:0] e, input logic [35:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask : chk_data

    task automatic chk_bits(input string w, input logic [3:0] e, input logic [3:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask : chk_bits

    task automatic stop_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // shared cycles
    // ------------------------------------------------------------
    task automatic quiet(input sbs_pkg::sbs_ctrl_type c);
        i_sbs_ctrl_model.pins(c, 18'h00004, 36'h0);
        i_sbs_ctrl_model.pins(12'hd7f, 18'h00000, 36'h0);
        repeat (6)
        begin
            @(posedge sys_clk_i);
            chk_bits("data_oe_o", 4'h0, oe_lanes);
        end
    endtask : quiet

    task automatic read_burst(input sbs_pkg::sbs_ctrl_type c, input logic [1:0] a,
                              input logic [2:0] wait_n);
        logic [35:0] got [4];
        logic [1:0]  cnt;
        got = '{default: 'x};
        cnt = 2'h0;
        fork
            begin
                i_sbs_ctrl_model.pins(c, {16'h0001, a}, 36'h0);
                for (int k = 0; k < 3; k++)
                    i_sbs_ctrl_model.pins(wait_n[k] ? 12'h5ff : 12'h5bf, 18'h3ffff, 36'h0);
                i_sbs_ctrl_model.pins(12'hd7f, 18'h00000, 36'h0);
            end
            begin
                repeat (8)
                    if (oe_lanes !== 4'hf)
                        @(posedge sys_clk_i);
                got[0] = rdata;
                for (int k = 1; k < 4; k++)
                begin
                    @(posedge sys_clk_i);
                    got[k] = rdata;
                end
            end
        join
        for (int k = 0; k < 4; k++)
        begin
            if (k > 0 && !wait_n[k-1])
                cnt++;
            chk_data("data_o", mem[{2'h1, order_reg ? a ^ cnt : a + cnt}], got[k]);
        end
    endtask : read_burst

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_write_read;
        for (int i = 4; i < 8; i++)
        begin
            mem[i] = 36'h9abcdef01 - 36'(i);
            i_sbs_ctrl_model.pins(12'h56f, 18'(i), mem[i]);
        end
        order_reg <= 1'b0;
        quiet(12'hd7f);
        read_burst(12'h4ff, 2'h1, 3'b000);
        order_reg <= 1'b1;
        quiet(12'hd7f);
        read_burst(12'h57f, 2'h2, 3'b010);
        $display("test write_read done");
    endtask : t_write_read

    task automatic t_bytes;
        mem[5][17:9] = 9'h1a5;
        i_sbs_ctrl_model.pins(12'h55d, 18'h00005, {9'h0, 9'h0, 9'h1a5, 9'h0});
        i_sbs_ctrl_model.pins(12'h570, 18'h00006, 36'h0);
        repeat (6) i_sbs_ctrl_model.pins(12'hd7f, 18'h00000, 36'h0);
        read_burst(12'h4ff, 2'h0, 3'b000);
        $display("test bytes done");
    endtask : t_bytes

    task automatic t_select;
        quiet(12'hcff);
        quiet(12'h17f);
        third_reg <= 1'b1;
        quiet(12'h77f);
        third_reg <= 1'b0;
        quiet(12'hd7f);
        read_burst(12'h77f, 2'h3, 3'b000);
        i_sbs_ctrl_model.levels(1'b1, 1'b0);
        quiet(12'h57f);
        i_sbs_ctrl_model.levels(1'b0, 1'b0);
        $display("test select done");
    endtask : t_select

    task automatic t_sleep;
        i_sbs_ctrl_model.levels(1'b0, 1'b1);
        repeat (4) @(posedge sys_clk_i);
        chk_bits("standby_o", 4'h1, {3'h0, standby});
        quiet(12'h4ff);
        i_sbs_ctrl_model.levels(1'b0, 1'b0);
        repeat (4) @(posedge sys_clk_i);
        chk_bits("standby_o", 4'h0, {3'h0, standby});
        $display("test sleep done");
    endtask : t_sleep

    initial
    begin
        errors      = 0;
        comparisons = 0;
        arst_n_i    = 1'b0;
        order_reg   = 1'b0;
        third_reg   = 1'b0;
        repeat (10) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        chk_data("data_o", `SBS_RST_DATA, rdata);
        chk_bits("data_oe_o", 4'h0, oe_lanes);
        t_write_read();
        t_bytes();
        t_select();
        t_sleep();
        stop_test();
    end

    // watchdog: far beyond the roughly 140 cycles the tests need
    initial
    begin
        #100us;
        errors++;
        stop_test();
    end
endmodule : sbs_sram_tb
